/* common/ciw_pkg.sv */
package ciw_pkg;
   localparam int unsigned PC_W     = 16;
   localparam int unsigned IRQ_W    = 8;
   localparam logic [15:0] PC_RST   = 16'h0000;
   localparam logic [15:0] PC_STEP  = 16'h0001;
   localparam logic [15:0] VEC_BASE = 16'h0002;
   localparam logic [15:0] VEC_NMI  = 16'h0024;

   typedef enum logic [2:0] {
      CIW_RUN   = 3'b001,
      CIW_IDLE  = 3'b010,
      CIW_WAKE  = 3'b100
   } ciw_state_e;

   typedef struct packed {
      logic        take;
      logic        nmi;
      logic [2:0]  num;
   } ciw_irq_s;
endpackage

/* rtl/ciw_core.sv */
`timescale 1ns/1ps
module ciw_core #(
   parameter int unsigned IRQ_W = ciw_pkg::IRQ_W
) (
   input  wire logic              ref_clk_i,
   input  wire logic              rst_i,
   input  wire logic              halt_exec_i,
   input  wire logic              step_i,
   input  wire logic              global_interrupt_mask_i,
   input  wire logic [IRQ_W-1:0]  irq_pend_i,
   input  wire logic [IRQ_W-1:0]  irq_en_i,
   input  wire logic              nmi_i,
   output logic [15:0]            pc_o,
   output logic                   power_down_o,
   output logic                   halted_o,
   output logic                   irq_take_o,
   output logic [15:0]            irq_vec_o
);
   ciw_pkg::ciw_state_e state_q, state_d;
   logic [15:0]         pc_q, pc_d;
   logic                pd_q, pd_d;
   logic                take_q, take_d;
   logic [15:0]         vec_q, vec_d;
   logic [IRQ_W-1:0]    pend_s1_q, pend_s2_q;
   logic [IRQ_W-1:0]    pend_s1_d, pend_s2_d;
   logic                nmi_s1_q, nmi_s2_q, nmi_prev_q;
   logic                nmi_s1_d, nmi_s2_d, nmi_prev_d;
   logic [IRQ_W-1:0]    act;
   logic                any_act, nmi_edge;
   logic [2:0]          num;

   // Request synchronisers
   always_comb begin
      pend_s1_d  = irq_pend_i;
      pend_s2_d  = pend_s1_q;
      nmi_s1_d   = nmi_i;
      nmi_s2_d   = nmi_s1_q;
      nmi_prev_d = nmi_s2_q;
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pend_s1_q  <= '0;
         pend_s2_q  <= '0;
         nmi_s1_q   <= 1'b0;
         nmi_s2_q   <= 1'b0;
         nmi_prev_q <= 1'b0;
      end else begin
         pend_s1_q  <= pend_s1_d;
         pend_s2_q  <= pend_s2_d;
         nmi_s1_q   <= nmi_s1_d;
         nmi_s2_q   <= nmi_s2_d;
         nmi_prev_q <= nmi_prev_d;
      end
   end

   always_comb begin
      act      = pend_s2_q & irq_en_i;
      any_act  = |act;
      nmi_edge = nmi_s2_q & ~nmi_prev_q;
      num      = '0;
      for (int i = IRQ_W - 1; i >= 0; i--) begin
         if (act[i]) begin
            num = 3'(i);
         end
      end
   end

   always_comb begin
      state_d = state_q;
      pc_d    = pc_q;
      pd_d    = pd_q;
      take_d  = 1'b0;
      vec_d   = vec_q;
      unique case (state_q)
         ciw_pkg::CIW_RUN: begin
            if (nmi_edge) begin
               take_d = 1'b1;
               vec_d  = ciw_pkg::VEC_NMI;
            end else if (any_act && !global_interrupt_mask_i) begin
               take_d = 1'b1;
               vec_d  = ciw_pkg::VEC_BASE + 16'(num);
            end else if (halt_exec_i) begin
               pc_d    = pc_q + ciw_pkg::PC_STEP;
               pd_d    = 1'b1;
               state_d = ciw_pkg::CIW_IDLE;
            end else if (step_i) begin
               pc_d = pc_q + ciw_pkg::PC_STEP;
            end
         end
         ciw_pkg::CIW_IDLE: begin
            if (nmi_edge || any_act) begin
               pd_d    = 1'b0;
               state_d = ciw_pkg::CIW_WAKE;
            end
         end
         ciw_pkg::CIW_WAKE: begin
            state_d = ciw_pkg::CIW_RUN;
            if (nmi_edge || nmi_s2_q) begin
               take_d = 1'b1;
               vec_d  = ciw_pkg::VEC_NMI;
            end else if (any_act && !global_interrupt_mask_i) begin
               take_d = 1'b1;
               vec_d  = ciw_pkg::VEC_BASE + 16'(num);
            end
         end
         default: begin
            state_d = ciw_pkg::CIW_RUN;
            pd_d    = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= ciw_pkg::CIW_RUN;
         pc_q    <= ciw_pkg::PC_RST;
         pd_q    <= 1'b0;
         take_q  <= 1'b0;
         vec_q   <= '0;
      end else begin
         state_q <= state_d;
         pc_q    <= pc_d;
         pd_q    <= pd_d;
         take_q  <= take_d;
         vec_q   <= vec_d;
      end
   end

   assign pc_o         = pc_q;
   assign power_down_o = pd_q;
   assign halted_o     = pd_q;
   assign irq_take_o   = take_q;
   assign irq_vec_o    = vec_q;

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   AST_PC_HOLD: assert property (pd_q && $past(pd_q) |-> pc_q == $past(pc_q))
      else $error("pc moved while halted");
   AST_PC_STEP: assert property (state_q == ciw_pkg::CIW_RUN && halt_exec_i && !nmi_edge && !any_act
      |=> pc_q == $past(pc_q) + ciw_pkg::PC_STEP && pd_q)
      else $error("pc not stepped once on halt");
   AST_PD_ENTRY: assert property (pd_q && !$past(pd_q) |-> pc_q == $past(pc_q) + ciw_pkg::PC_STEP)
      else $error("power down without single pc step");
   AST_IDLE_STEP: assert property (state_q == ciw_pkg::CIW_IDLE && step_i |=> $stable(pc_q))
      else $error("pc stepped while idle");
   AST_PD_IDLE: assert property (state_q == ciw_pkg::CIW_IDLE |-> pd_q)
      else $error("idle without power down");
   AST_PD_EXIT: assert property (!pd_q && $past(pd_q) |-> state_q == ciw_pkg::CIW_WAKE)
      else $error("power down left without wake");
   AST_HOLD: assert property (state_q == ciw_pkg::CIW_IDLE && !nmi_edge && !any_act
      |=> state_q == ciw_pkg::CIW_IDLE)
      else $error("left idle without wake");
   AST_IDLE_NO_TAKE: assert property (state_q == ciw_pkg::CIW_IDLE |-> !take_q)
      else $error("branch taken while idle");
   AST_WAKE_ENTRY: assert property (state_q == ciw_pkg::CIW_IDLE && (nmi_edge || any_act)
      |=> state_q == ciw_pkg::CIW_WAKE && $stable(pc_q))
      else $error("wake request not honoured");
   AST_NMI_WAKE: assert property (state_q == ciw_pkg::CIW_WAKE && nmi_s2_q
      |=> take_q && vec_q == ciw_pkg::VEC_NMI)
      else $error("no nmi branch after wake");
   AST_WAKE_MASKED: assert property (state_q == ciw_pkg::CIW_IDLE && any_act && global_interrupt_mask_i
      |=> !pd_q)
      else $error("masked wake ignored");
   AST_WAKE_PERIPH: assert property (state_q == ciw_pkg::CIW_IDLE && any_act
      |=> state_q == ciw_pkg::CIW_WAKE)
      else $error("peripheral request did not wake");
   AST_RUN_BLOCK: assert property (state_q == ciw_pkg::CIW_RUN && !nmi_edge && global_interrupt_mask_i
      |=> !take_q)
      else $error("maskable irq taken with mask set");
   AST_RUN_TAKE: assert property (state_q == ciw_pkg::CIW_RUN && !nmi_edge && any_act
      && !global_interrupt_mask_i |=> take_q && vec_q == ciw_pkg::VEC_BASE + 16'($past(num)))
      else $error("unmasked irq not taken while running");
   AST_NMI_RUN: assert property (state_q == ciw_pkg::CIW_RUN && nmi_edge
      |=> take_q && vec_q == ciw_pkg::VEC_NMI)
      else $error("nmi not taken while running");
   AST_STEP_RUN: assert property (state_q == ciw_pkg::CIW_RUN && step_i && !halt_exec_i && !nmi_edge
      && !(any_act && !global_interrupt_mask_i) |=> pc_q == $past(pc_q) + ciw_pkg::PC_STEP)
      else $error("pc not stepped on retire");
   AST_BRANCH: assert property (state_q == ciw_pkg::CIW_WAKE && any_act && !global_interrupt_mask_i
      && !nmi_s2_q |=> take_q && vec_q == ciw_pkg::VEC_BASE + 16'($past(num)))
      else $error("no branch after wake with mask clear");
   AST_VEC_HOLD: assert property ($changed(vec_q) |-> take_q)
      else $error("vector changed without branch");
   AST_RESUME: assert property (state_q == ciw_pkg::CIW_WAKE && global_interrupt_mask_i && !nmi_s2_q
      |=> !take_q && state_q == ciw_pkg::CIW_RUN && $stable(pc_q))
      else $error("branch taken after wake with mask set");
   AST_WAKE_ONE: assert property (state_q == ciw_pkg::CIW_WAKE |=> state_q == ciw_pkg::CIW_RUN)
      else $error("wake state not left after one cycle");
   AST_DETECT: assert property (state_q == ciw_pkg::CIW_IDLE && nmi_edge |=> !pd_q)
      else $error("nmi not seen while powered down");

   COV_IDLE: cover property (state_q == ciw_pkg::CIW_IDLE);
   COV_BR: cover property (state_q == ciw_pkg::CIW_WAKE ##1 take_q);
   COV_RES: cover property (state_q == ciw_pkg::CIW_WAKE && global_interrupt_mask_i ##1 !take_q);
   COV_NMI: cover property (state_q == ciw_pkg::CIW_IDLE && nmi_edge);
   COV_NMI_RUN: cover property (state_q == ciw_pkg::CIW_RUN && nmi_edge ##1 take_q);
endmodule

/* test/ciw_src.sv */
`timescale 1ns/1ps
module ciw_src (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic [7:0] set_i,
   input  wire logic       clr_i,
   output logic      [7:0] irq_pend_o
);
   // peripheral requests
   // Lines stay up until taken or cleared
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i)
         irq_pend_o <= 8'h00;
      else if (clr_i)
         irq_pend_o <= 8'h00;
      else
         irq_pend_o <= irq_pend_o | set_i;
   end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   typedef struct packed {
      logic        m;
      logic [7:0]  e;
      logic [7:0]  s;
      logic [15:0] t;
      logic [15:0] v;
   } ciw_row_s;
   logic        clk = 0, rst = 1, halt = 0, step = 0, mask = 0, nmi = 0, clr = 0;
   logic [7:0]  en = 8'h00, set = 8'h00, pend;
   logic [15:0] pc, vec, vec_seen;
   logic        pd, hlt, take;
   int          errors = 0, cmp_count = 0, takes = 0, n;
   ciw_row_s    rows [3] = '{'{1'b0, 8'hff, 8'h08, 16'h1, 16'h0005},
                             '{1'b1, 8'hff, 8'h08, 16'h0, 16'h0000},
                             '{1'b0, 8'h06, 8'h0e, 16'h1, 16'h0003}};
   ciw_src src (.clk_i(clk), .rst_i(rst), .set_i(set), .clr_i(clr | take), .irq_pend_o(pend));
   ciw_core dut (.ref_clk_i(clk), .rst_i(rst), .halt_exec_i(halt), .step_i(step),
      .global_interrupt_mask_i(mask), .irq_pend_i(pend), .irq_en_i(en), .nmi_i(nmi),
      .pc_o(pc), .power_down_o(pd), .halted_o(hlt), .irq_take_o(take), .irq_vec_o(vec));
   initial forever #20 clk = ~clk;
   // Service entry sets the mask
   always @(posedge clk) if (take === 1'b1) begin
      if (takes == 0) vec_seen = vec;
      takes++;
      mask <= 1'b1;
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      cmp_count++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic summarize;
      if (errors == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clk);
   endtask
   task automatic reset;
      rst <= 1'b1;
      cyc(8);
      rst <= 1'b0;
      takes = 0;
      vec_seen = '0;
      cyc(1);
   endtask
   // Halt, then retire attempts while idle
   task automatic go_idle(logic [15:0] p);
      halt <= 1'b1;
      cyc(1);
      halt <= 1'b0;
      step <= 1'b1;
      cyc(4);
      step <= 1'b0;
      chk("pc", p, pc);
      chk("pd", 16'h0001, {15'h0, pd});
      chk("halted", 16'h0001, {15'h0, hlt});
   endtask
   task automatic wake(logic [15:0] t, logic [15:0] v);
      n = 0;
      while (pd !== 1'b0 && n < 12) begin
         cyc(1);
         n++;
      end
      cyc(4);
      chk("pd", 16'h0000, {15'h0, pd});
      chk("take", t, {15'h0, takes != 0});
      if (t[0]) chk("vec", v, vec_seen);
   endtask
   initial begin
      cyc(3000);
      errors++;
      summarize();
   end
   initial begin
      reset();
      foreach (rows[i]) begin
         reset();
         mask <= rows[i].m;
         en <= rows[i].e;
         go_idle(16'h0001);
         set <= rows[i].s;
         cyc(1);
         set <= 8'h00;
         wake(rows[i].t, rows[i].v);
         clr <= 1'b1;
         cyc(1);
         clr <= 1'b0;
      end
      reset();
      go_idle(16'h0001);
      set <= 8'h01;
      cyc(1);
      set <= 8'h00;
      cyc(12);
      chk("pd", 16'h0001, {15'h0, pd});
      nmi <= 1'b1;
      wake(16'h1, 16'h0024);
      nmi <= 1'b0;
      go_idle(16'h0002);
      reset();
      chk("pc", 16'h0000, pc);
      chk("pd", 16'h0000, {15'h0, pd});
      step <= 1'b1;
      cyc(3);
      step <= 1'b0;
      cyc(1);
      chk("pc", 16'h0003, pc);
      nmi <= 1'b1;
      cyc(6);
      nmi <= 1'b0;
      chk("take", 16'h0001, {15'h0, takes != 0});
      chk("vec", 16'h0024, vec_seen);
      summarize();
   end
endmodule
